// file: core/loader_power_mgmt_config_regs.sv
// Purpose: Power management and revision control configuration registers.
// Assumes: Configuration cycles arrive decoded as dword index, byte enables and strobes.
// Notes: Read data is registered, one cycle after the read strobe.
`default_nettype none
`include "lpmc_consts.svh"
module loader_power_mgmt_config_regs
  import lpmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_byte_en,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cmd_int_disable,
  input wire logic stat_int_pending,
  output logic [31:0] cfg_rdata,
  output logic cfg_hit,
  output logic [1:0] power_level_field,
  output logic newer_bus_rev_enable,
  output logic int_disable_active,
  output logic int_status_visible
);
  lpmc_wr_if wr();
  // The dword decode feeds both the read mux and the write strobes, so it is written once.
  function automatic logic dword_is(input logic [5:0] idx, input logic [5:0] target);
    return (idx == target);
  endfunction
  wire hit_pm = dword_is(cfg_dword, `LPMC_DW_PM);
  wire hit_misc = dword_is(cfg_dword, `LPMC_DW_MISC);
  assign wr.pm_wr = cfg_wr && hit_pm && cfg_byte_en[0];
  assign wr.misc_wr = cfg_wr && hit_misc && cfg_byte_en[0];
  assign wr.pm_val = cfg_wdata[1:0];
  assign wr.rev_val = cfg_wdata[0];
  lpmc_store u_store (
    .clk(clk),
    .rst(rst),
    .wr(wr)
  );
  wire [15:0] pm_word = {1'b0, 2'b00, 4'h0, 1'b0, 6'h00, wr.power_level};
  wire [31:0] pm_dword = {`LPMC_FIXED_BYTE, `LPMC_FIXED_BYTE, pm_word};
  wire [31:0] misc_dword = {24'h000000, 7'h00, wr.rev_enable};
  wire [31:0] next_rdata = hit_pm ? pm_dword : (hit_misc ? misc_dword : 32'h00000000);
  wire next_int_dis = wr.rev_enable & cmd_int_disable;
  wire next_int_stat = wr.rev_enable & stat_int_pending;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_rdata <= 32'h00000000;
      cfg_hit <= 1'b0;
      power_level_field <= `LPMC_PWR_RESET;
      newer_bus_rev_enable <= `LPMC_REV_RESET;
      int_disable_active <= 1'b0;
      int_status_visible <= 1'b0;
    end
    else
    begin
      cfg_rdata <= cfg_rd ? next_rdata : 32'h00000000;
      cfg_hit <= (cfg_rd || cfg_wr) && (hit_pm || hit_misc);
      power_level_field <= wr.power_level;
      newer_bus_rev_enable <= wr.rev_enable;
      int_disable_active <= next_int_dis;
      int_status_visible <= next_int_stat;
    end
  end

  // Read-path checks look one edge after the strobe, where the registered word stands; the two top-byte checks hold on every edge.

  // power level follows write
  // The stored field moves one edge after the write and the output one edge later.
  AST_PWR_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr.pm_wr |=> ##1 power_level_field == $past(cfg_wdata[1:0], 2))
    else $error("power level did not follow write");

  // power level read back
  // A read taken just after reset sees cleared data, so that edge is left out.
  AST_PM_READ_LEVEL: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_pm && !rst) |-> cfg_rdata[1:0] == $past(wr.power_level))
    else $error("power level read back wrong");

  AST_WAKE_ZERO: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd) |-> cfg_rdata[15:2] == 14'h0000)
    else $error("fixed control/status bits not zero");

  AST_DATA_SCALE_ZERO: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_pm) |-> cfg_rdata[14:13] == 2'h0)
    else $error("data scale field not zero");

  AST_DATA_SEL_ZERO: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_pm) |-> cfg_rdata[12:9] == 4'h0)
    else $error("data select field not zero");

  // wake enable zero
  // A host that sets the enable bit must still read it back as zero.
  AST_WAKE_EN_ZERO: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_pm) |-> !cfg_rdata[`LPMC_WAKE_EN_BIT])
    else $error("wake enable bit not zero");

  AST_PM_RSVD: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_pm) |-> cfg_rdata[7:2] == 6'h00)
    else $error("control/status reserved bits not zero");

  // each fixed bit alone
  // One check per bit names the exact bit when a field decode slips.
  for (genvar gi = 2; gi < 16; gi++)
  begin : g_fixed_zero
    AST_FIXED_BIT: assert property (@(posedge clk) disable iff (rst)
      $past(cfg_rd && hit_pm) |-> !cfg_rdata[gi])
      else $error("fixed control/status bit set");
  end

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
    cfg_rdata[23:16] == 8'h00)
    else $error("bridge extension byte not zero");

  AST_DATA_BYTE_ZERO: assert property (@(posedge clk) disable iff (rst)
    cfg_rdata[31:24] == 8'h00)
    else $error("power data byte not zero");

  AST_MISC_RSVD: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_misc) |-> cfg_rdata[7:1] == 7'h00)
    else $error("misc reserved bits not zero");

  AST_REV_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr.misc_wr |=> ##1 newer_bus_rev_enable == $past(cfg_wdata[0], 2))
    else $error("revision bit did not follow write");

  AST_MISC_READ_REV: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd && hit_misc && !rst) |-> cfg_rdata[0] == $past(wr.rev_enable))
    else $error("revision bit read back wrong");

  AST_REV_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wr.misc_wr |=> $stable(wr.rev_enable))
    else $error("revision bit changed without write");

  AST_REV_GATE: assert property (@(posedge clk) disable iff (rst)
    !$past(wr.rev_enable) |-> !int_disable_active && !int_status_visible)
    else $error("interrupt bits active in revision 2.2 mode");

  // pass through in revision 2.3
  // The edge after a reset is skipped: the outputs were cleared there whatever the mode was.
  AST_REV_PASS: assert property (@(posedge clk) disable iff (rst)
    ($past(wr.rev_enable) && !$past(rst)) |->
    (int_disable_active == $past(cmd_int_disable)) &&
    (int_status_visible == $past(stat_int_pending)))
    else $error("interrupt bits not passed in revision 2.3 mode");

  AST_RO_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (cfg_wr && !wr.pm_wr && !wr.misc_wr) |=> $stable(wr.power_level) && $stable(wr.rev_enable))
    else $error("ignored write changed state");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (rst)
    $past((cfg_rd || cfg_wr) && !hit_pm && !hit_misc) |-> !cfg_hit && cfg_rdata == 32'h00000000)
    else $error("unmapped access returned data or hit");

  // idle read data zero
  // Keeping the bus word zero between reads stops stale data being taken for a fresh answer.
  AST_RD_IDLE_ZERO: assert property (@(posedge clk) disable iff (rst)
    !$past(cfg_rd) |-> cfg_rdata == 32'h00000000)
    else $error("read data not zero between reads");

  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wr.pm_wr |=> $stable(wr.power_level))
    else $error("power level changed without write");

  // Main scenarios that the bench is expected to reach.
  COV_D3: cover property (@(posedge clk) wr.power_level == LPMC_D3HOT);
  COV_REV23: cover property (@(posedge clk) newer_bus_rev_enable && int_status_visible);
  COV_MISC_RD: cover property (@(posedge clk) cfg_rd && hit_misc);
  COV_PM_RD: cover property (@(posedge clk) cfg_rd && hit_pm);
  COV_RO_WR: cover property (@(posedge clk) cfg_wr && hit_pm && !cfg_byte_en[0]);
endmodule // loader_power_mgmt_config_regs
`default_nettype wire

// file: core/lpmc_consts.svh
// Purpose: Offsets, field positions and reset values of the loader power registers.
// Assumes: Configuration accesses are dword aligned with four byte enables.
// Notes: Definitions only.
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH
`define LPMC_DW_PM 6'h12
`define LPMC_DW_MISC 6'h14
`define LPMC_OFF_PM_CTRL 8'h48
`define LPMC_OFF_BRIDGE_EXT 8'h4a
`define LPMC_OFF_PM_DATA 8'h4b
`define LPMC_OFF_MISC 8'h50
`define LPMC_PWR_RESET 2'h0
`define LPMC_REV_RESET 1'h0
`define LPMC_FIXED_BYTE 8'h00
`define LPMC_WAKE_FLAG_BIT 15
`define LPMC_WAKE_EN_BIT 8
`endif

// file: core/lpmc_pkg.sv
// Purpose: Types shared by the loader power register bank.
// Assumes: Nothing beyond the constants header.
// Notes: Power level encoding follows the control/status field.
`default_nettype none
package lpmc_pkg;
  typedef enum logic [1:0] {
    LPMC_D0 = 2'b00,
    LPMC_D1 = 2'b01,
    LPMC_D2 = 2'b10,
    LPMC_D3HOT = 2'b11
  } lpmc_power_t;
endpackage
`default_nettype wire

// file: core/lpmc_if.sv
// Purpose: Decoded write strobes passed from the bank to the field store.
// Assumes: One clock domain.
// Notes: Strobes are single-cycle.
`default_nettype none
interface lpmc_wr_if;
  logic pm_wr;
  logic misc_wr;
  logic [1:0] pm_val;
  logic rev_val;
  logic [1:0] power_level;
  logic rev_enable;
  modport bank(output pm_wr, output misc_wr, output pm_val, output rev_val,
    input power_level, input rev_enable);
  modport store(input pm_wr, input misc_wr, input pm_val, input rev_val,
    output power_level, output rev_enable);
endinterface
`default_nettype wire

// file: core/lpmc_store.sv
// Purpose: Holds the writable fields of the loader power register bank.
// Assumes: Only the function reset input clears it.
// Notes: The D3hot to D0 soft reset is not wired here on purpose.
`default_nettype none
`include "lpmc_consts.svh"
module lpmc_store
  import lpmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  lpmc_wr_if.store wr
);
  // survives soft reset
  // The internal D3hot exit reset never reaches these flops, so the field survives it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr.power_level <= `LPMC_PWR_RESET;
      wr.rev_enable <= `LPMC_REV_RESET;
    end
    else
    begin
      if (wr.pm_wr)
        wr.power_level <= wr.pm_val;
      if (wr.misc_wr)
        wr.rev_enable <= wr.rev_val;
    end
  end
endmodule // lpmc_store
`default_nettype wire

// file: testbench/lpmc_host.sv
// Purpose: Host model that issues configuration reads and writes.
// Assumes: One dword access per call, strobe held for one edge.
// Notes: Idle write data shows the inverse of the last value.
`default_nettype none
module lpmc_host (
  input wire logic clk,
  output logic [5:0] dw,
  output logic [3:0] be,
  output logic rd,
  output logic wr,
  output logic [31:0] wd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {dw, be, rd, wr, wd} = '0;
  end
  // Released data is inverted so a stale value can never pass for a write.
  task automatic access(input logic w, input logic [5:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(posedge clk);
    #1;
    {dw, be, wr, rd, wd} = {a, b, w, !w, d};
    @(posedge clk);
    #1;
    {wr, rd, wd} = {2'b00, ~d};
  endtask
endmodule // lpmc_host
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the loader power register bank.
// Assumes: The host model spaces accesses by the contract.
// Notes: Random data comes from a 16-bit shift register.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cid, sip, hit, nbr, ida, isv, wr, rd;
  logic [5:0] dw;
  logic [3:0] be;
  logic [31:0] wd, rdata, d;
  logic [1:0] plf;
  logic [15:0] seed;
  int error_cnt, compares;
  lpmc_host host (.clk(clk), .dw(dw), .be(be), .rd(rd), .wr(wr), .wd(wd));
  loader_power_mgmt_config_regs DUT (.clk(clk), .rst(rst), .cfg_dword(dw),
    .cfg_byte_en(be), .cfg_rd(rd), .cfg_wr(wr), .cfg_wdata(wd), .cmd_int_disable(cid),
    .stat_int_pending(sip), .cfg_rdata(rdata), .cfg_hit(hit), .power_level_field(plf),
    .newer_bus_rev_enable(nbr), .int_disable_active(ida), .int_status_visible(isv));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Only the power level survives; every other bit of the dword reads zero.
  function automatic logic [31:0] exp_pm(input logic [31:0] v);
    return {30'h0, v[1:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e, input logic h);
    host.access(1'b0, a, 4'hf, 32'h0);
    chk(rdata, e);
    chk({31'h0, hit}, {31'h0, h});
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rst, cid, sip, error_cnt, compares, seed} = {3'b100, 64'h0, 16'h000e};
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({28'h0, plf, nbr, ida}, 32'h0);
    rdchk(6'h12, 32'h0, 1'b1);
    rdchk(6'h14, 32'h0, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'hffff_ffff : {seed, lfsr(seed)};
      cid = seed[3];
      sip = seed[5];
      host.access(1'b1, 6'h12, 4'hf, d);
      host.access(1'b1, 6'h14, 4'hf, ~d);
      repeat (2) @(posedge clk);
      #1;
      chk({30'h0, plf}, {30'h0, d[1:0]});
      chk({29'h0, nbr, ida, isv}, {29'h0, ~d[0], ~d[0] & cid, ~d[0] & sip});
      rdchk(6'h12, exp_pm(d), 1'b1);
      rdchk(6'h14, {31'h0, ~d[0]}, 1'b1);
    end
    // Writes lacking byte 0, or aimed elsewhere, must leave state alone.
    host.access(1'b1, 6'h12, 4'he, ~d);
    host.access(1'b1, 6'h13, 4'hf, ~d);
    host.access(1'b1, 6'h14, 4'he, d);
    repeat (2) @(posedge clk);
    #1;
    chk({30'h0, plf}, {30'h0, d[1:0]});
    chk({31'h0, nbr}, {31'h0, ~d[0]});
    rdchk(6'h13, 32'h0, 1'b0);
    // A reset in mid-run must clear the revision select even with the header inputs high.
    cid = 1'b1;
    sip = 1'b1;
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk({28'h0, plf, nbr, ida}, 32'h0);
    rdchk(6'h14, 32'h0, 1'b1);
    test_done();
  end
endmodule // tb
`default_nettype wire
